// ### src/nbc_host.sv
// host controller driving the flash bus cycles from a request port
`timescale 1ns/1ns
module nbc_host (
	input wire logic clk,
	input wire logic arst_n,
	input wire nbc_pkg::nbc_req_t req,
	input wire logic req_valid,
	output logic req_ready,
	output nbc_pkg::nbc_rsp_t rsp,
	output logic rsp_valid,
	input wire logic prog_allow,
	output logic line_ready,
	output nbc_pkg::nbc_pins_t pins,
	output logic [nbc_pkg::BUS_W-1:0] dq_out,
	output logic dq_oe_n,
	input wire logic [nbc_pkg::BUS_W-1:0] dq_in,
	input wire logic busy_flag_n
);
	import nbc_pkg::*;

	// bus value for a write-type cycle; command and address use the low lane only
	function automatic logic [BUS_W-1:0] lane_of(input nbc_op_t op, input logic [WDATA_W-1:0] w);
		if (op == NBC_OP_WRITE) begin
			return w[BUS_W-1:0];
		end
		return {LANE_ZERO, w[LANE_W-1:0]}; // see RL18
	endfunction

	nbc_state_t state, next_state; // cycle sequencer
	logic [CNT_W-1:0] cnt, next_cnt; // phase timer
	nbc_pins_t next_pins;
	logic [BUS_W-1:0] next_dq_out;
	logic next_dq_oe_n, next_req_ready, next_rsp_valid;
	nbc_rsp_t next_rsp;
	nbc_op_t cur_op, next_cur_op; // operation in flight
	logic deselect, next_deselect;
	logic [WDATA_W-1:0] addr_sr, next_addr_sr; // address bytes, shifted out low first
	logic [1:0] byte_idx, next_byte_idx;
	logic [BUS_W-1:0] dq_s; // synchronised data lanes
	logic busy_s; // synchronised busy line, high means ready
	logic next_line_ready;

	// pins from the flash pass two flops before anything reads them
	nbc_sync #(.W(BUS_W + 1)) u_sync (
		.clk(clk),
		.arst_n(arst_n),
		.d({dq_in, busy_flag_n}),
		.q({dq_s, busy_s})
	);

	// decode of the current phase
	wire is_read = (cur_op == NBC_OP_READ);
	wire is_addr = (cur_op == NBC_OP_ADDR);
	wire take = req_valid && req_ready;
	wire [CNT_W-1:0] strobe_last = is_read ? RD_LOW_LAST : WE_LOW_LAST;
	wire more_addr = is_addr && (byte_idx != ADDR_IDX_LAST);
	wire [WDATA_W-1:0] addr_shifted = {LANE_ZERO, addr_sr[WDATA_W-1:LANE_W]};
	wire [CNT_W-1:0] cnt_inc = cnt + 1'b1;
	wire is_write_op = (req.op == NBC_OP_CMD) || (req.op == NBC_OP_ADDR) || (req.op == NBC_OP_WRITE);

	// sequencer: setup, strobe low, strobe high, repeat for address bytes
	always_comb begin
		next_state = state;
		next_cnt = cnt_inc;
		next_pins = pins;
		next_dq_out = dq_out;
		next_dq_oe_n = dq_oe_n;
		next_req_ready = req_ready;
		next_rsp = rsp;
		next_rsp_valid = 1'b0;
		next_cur_op = cur_op;
		next_deselect = deselect;
		next_addr_sr = addr_sr;
		next_byte_idx = byte_idx;
		next_line_ready = busy_s;
		case (state)
			NBC_ST_RECOVER: begin
				// write enable high and lockout low for the whole recovery
				next_pins = PINS_RESET; // see RL9, RL12
				if (cnt == REC_LAST) begin
					next_cnt = cnt;
					// recovery served; also wait for the device to release busy
					if (busy_s) begin // see RL8
						next_state = NBC_ST_IDLE;
						next_req_ready = 1'b1;
						next_cnt = '0;
					end
				end
			end
			NBC_ST_IDLE: begin
				next_cnt = '0;
				// lockout follows the user level each idle cycle, held through a request
				next_pins.wp_n = prog_allow; // see RL10, RL11
				if (take) begin
					next_req_ready = 1'b0;
					next_cur_op = req.op;
					next_deselect = req.deselect;
					next_addr_sr = req.wdata;
					next_byte_idx = '0;
					next_rsp = '0;
					if (req.op == NBC_OP_WAIT) begin
						next_state = NBC_ST_WAIT;
					end else begin
						next_state = NBC_ST_SETUP;
						next_pins.ce_n = 1'b0; // see RL3
						// strobes are mutually exclusive by the op decode
						next_pins.command_latch_strobe = (req.op == NBC_OP_CMD); // see RL2, RL15, RL25
						next_pins.address_latch_strobe = (req.op == NBC_OP_ADDR); // see RL1, RL17, RL25
						next_dq_out = lane_of(req.op, req.wdata);
						next_dq_oe_n = !is_write_op; // see RL23
					end
				end
			end
			NBC_ST_SETUP: begin
				if (cnt == SETUP_LAST) begin
					next_state = NBC_ST_STROBE;
					next_cnt = '0;
					next_pins.re_n = !is_read; // see RL6, RL20
					next_pins.we_n = is_read; // see RL19
				end
			end
			NBC_ST_STROBE: begin
				if (cnt == strobe_last) begin
					next_state = NBC_ST_HOLD;
					next_cnt = '0;
					// the device latches on this write rise
					next_pins.we_n = 1'b1; // see RL7
					next_pins.re_n = 1'b1;
					if (is_read) begin
						next_rsp.rdata = dq_s; // see RL21
					end
				end
			end
			NBC_ST_HOLD: begin
				if (cnt == HIGH_LAST) begin
					next_cnt = '0;
					if (more_addr) begin
						// next address byte, data changes only while write enable is high
						next_state = NBC_ST_SETUP; // see RL16
						next_byte_idx = byte_idx + 1'b1;
						next_addr_sr = addr_shifted;
						next_dq_out = lane_of(NBC_OP_ADDR, addr_shifted);
					end else begin
						next_state = NBC_ST_IDLE;
						next_pins.command_latch_strobe = 1'b0;
						next_pins.address_latch_strobe = 1'b0;
						next_pins.ce_n = deselect; // see RL24
						next_dq_oe_n = 1'b1;
						next_rsp_valid = 1'b1;
						next_req_ready = 1'b1;
					end
				end
			end
			NBC_ST_WAIT: begin
				// busy falls some time after the strobe; skip that window first
				if (cnt >= SETTLE_LAST) begin
					next_cnt = cnt;
					if (busy_s) begin // see RL13, RL14
						next_state = NBC_ST_IDLE;
						next_cnt = '0;
						next_pins.ce_n = deselect ? 1'b1 : pins.ce_n;
						next_rsp_valid = 1'b1;
						next_req_ready = 1'b1;
					end
				end
			end
			default: begin
				next_state = NBC_ST_RECOVER;
				next_cnt = '0;
				next_pins = PINS_RESET;
			end
		endcase
	end

	// state and pin registers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= NBC_ST_RECOVER;
			cnt <= '0;
			pins <= PINS_RESET;
			dq_out <= '0;
			dq_oe_n <= 1'b1;
			req_ready <= 1'b0;
			rsp <= '0;
			rsp_valid <= 1'b0;
			line_ready <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			pins <= next_pins;
			dq_out <= next_dq_out;
			dq_oe_n <= next_dq_oe_n;
			req_ready <= next_req_ready;
			rsp <= next_rsp;
			rsp_valid <= next_rsp_valid;
			line_ready <= next_line_ready;
		end
	end

	// request context
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cur_op <= NBC_OP_CMD;
			deselect <= 1'b0;
			addr_sr <= '0;
			byte_idx <= '0;
		end else begin
			cur_op <= next_cur_op;
			deselect <= next_deselect;
			addr_sr <= next_addr_sr;
			byte_idx <= next_byte_idx;
		end
	end

	// helper: address write rises seen for the current request
	logic [2:0] addr_we_cnt;
	logic we_q;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			addr_we_cnt <= '0;
			we_q <= 1'b1;
		end else begin
			we_q <= pins.we_n;
			if (take) begin
				addr_we_cnt <= '0;
			end else if (pins.we_n && !we_q && pins.address_latch_strobe) begin
				addr_we_cnt <= addr_we_cnt + 1'b1;
			end
		end
	end

	property p_strobes_exclusive;
		@(posedge clk) disable iff (!arst_n) !(pins.command_latch_strobe && pins.address_latch_strobe);
	endproperty
	a_strobes_exclusive: assert property (p_strobes_exclusive) else $error("both latch strobes high"); // see RL25

	property p_recover_we_high;
		@(posedge clk) disable iff (!arst_n) (state == NBC_ST_RECOVER) |-> pins.we_n && pins.ce_n;
	endproperty
	a_recover_we_high: assert property (p_recover_we_high) else $error("write enable low in recovery"); // see RL9

	property p_recover_wp_low;
		@(posedge clk) disable iff (!arst_n) (state == NBC_ST_RECOVER) |-> !pins.wp_n && !req_ready;
	endproperty
	a_recover_wp_low: assert property (p_recover_wp_low) else $error("lockout released in recovery"); // see RL12

	property p_recover_len;
		@(posedge clk) disable iff (!arst_n) (state == NBC_ST_RECOVER && cnt < REC_LAST) |=> state == NBC_ST_RECOVER;
	endproperty
	a_recover_len: assert property (p_recover_len) else $error("recovery cut short"); // see RL8

	property p_cmd_cycle;
		@(posedge clk) disable iff (!arst_n)
			($rose(pins.we_n) && pins.command_latch_strobe) |-> !pins.ce_n && !pins.address_latch_strobe && pins.re_n
			&& !dq_oe_n && dq_out[BUS_W-1:LANE_W] == LANE_ZERO;
	endproperty
	a_cmd_cycle: assert property (p_cmd_cycle) else $error("bad command cycle"); // see RL15

	property p_addr_cycle;
		@(posedge clk) disable iff (!arst_n)
			($rose(pins.we_n) && pins.address_latch_strobe) |-> !pins.ce_n && !pins.command_latch_strobe && pins.re_n
			&& $stable(dq_out);
	endproperty
	a_addr_cycle: assert property (p_addr_cycle) else $error("bad address cycle"); // see RL17

	property p_addr_four;
		@(posedge clk) disable iff (!arst_n) (rsp_valid && cur_op == NBC_OP_ADDR) |-> addr_we_cnt == ADDR_COUNT;
	endproperty
	a_addr_four: assert property (p_addr_four) else $error("address op not four cycles"); // see RL16

	property p_data_in;
		@(posedge clk) disable iff (!arst_n)
			($rose(pins.we_n) && cur_op == NBC_OP_WRITE) |-> !pins.ce_n && pins.re_n && !dq_oe_n
			&& !pins.command_latch_strobe && !pins.address_latch_strobe;
	endproperty
	a_data_in: assert property (p_data_in) else $error("bad data input cycle"); // see RL19

	property p_data_out;
		@(posedge clk) disable iff (!arst_n)
			!pins.re_n |-> !pins.ce_n && pins.we_n && dq_oe_n && !pins.command_latch_strobe && !pins.address_latch_strobe;
	endproperty
	a_data_out: assert property (p_data_out) else $error("bad data output cycle"); // see RL20
endmodule

// ### src/nbc_pkg.sv
// constants, types and pin synchroniser for the flash bus-cycle host
// Operation
// RL1 - address strobe high: write rise takes address
// RL2 - command strobe high: write rise takes command
// RL3 - device active only while chip enable low
// RL4 - busy program/erase keeps device selected
// RL5 - enable-don't-care: read busy survives enable high
// RL6 - each read fall gives next word
// RL7 - address and data taken on write rise
// RL8 - recovery of 10 us, busy low throughout
// RL9 - controller keeps write enable high in recovery
// RL10 - lockout low rejects every program or erase
// RL11 - lockout acts on level, not sampled
// RL12 - controller drives lockout low around power transitions
// RL13 - busy line low while operation runs
// RL14 - busy line is open-drain, wired low
// RL15 - command: enable low, command strobe, read high
// RL16 - four address cycles after the command
// RL17 - address: enable low, address strobe, read high
// RL18 - address uses bus bits 0 to 7
// RL19 - data in: strobes low, one word per rise
// RL20 - data out: write high, strobes low, sequential
// RL21 - read path returns array, status, signature, serial
// RL22 - low supply disables all device functions
// RL23 - data lanes released when deselected or disabled
// RL24 - enable high without busy means standby
// RL25 - never both latch strobes during write pulse
`timescale 1ns/1ns
package nbc_pkg;
	localparam int CLK_PERIOD_NS = 20; // 50 MHz system clock
	// least time in ns to whole cycles, never under one
	function automatic int ns2cyc(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		if (c < 1) begin
			c = 1;
		end
		return c;
	endfunction
	localparam int RECOVERY_NS = 10000; // power transition recovery, 10 us
	localparam int SETUP_NS = 20; // strobe setup before a pulse
	localparam int WE_LOW_NS = 40; // write enable low width
	localparam int STROBE_HIGH_NS = 40; // strobe high width and hold
	localparam int READ_TO_OUTPUT_VALID_NS = 60; // read_to_output_valid
	localparam int BUSY_SETTLE_NS = 200; // time for busy line to fall after a command
	localparam int SYNC_STAGES = 2; // pin synchroniser depth
	localparam int CNT_W = 10;
	localparam logic [CNT_W-1:0] REC_LAST = CNT_W'(ns2cyc(RECOVERY_NS) - 1);
	localparam logic [CNT_W-1:0] SETUP_LAST = CNT_W'(ns2cyc(SETUP_NS) - 1);
	localparam logic [CNT_W-1:0] WE_LOW_LAST = CNT_W'(ns2cyc(WE_LOW_NS) - 1);
	localparam logic [CNT_W-1:0] HIGH_LAST = CNT_W'(ns2cyc(STROBE_HIGH_NS) - 1);
	// read low covers output valid time plus synchroniser latency
	localparam logic [CNT_W-1:0] RD_LOW_LAST = CNT_W'(ns2cyc(READ_TO_OUTPUT_VALID_NS) + SYNC_STAGES);
	localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(ns2cyc(BUSY_SETTLE_NS) - 1);
	localparam int BUS_W = 16; // x16 bus, x8 parts use the low lane
	localparam int LANE_W = 8;
	localparam int WDATA_W = 32;
	localparam int ADDR_BYTES = 4;
	localparam logic [1:0] ADDR_IDX_LAST = 2'(ADDR_BYTES - 1);
	localparam logic [2:0] ADDR_COUNT = 3'(ADDR_BYTES);
	localparam logic [LANE_W-1:0] LANE_ZERO = 8'h00;
	typedef enum logic [2:0] {
		NBC_OP_CMD = 3'h0, // one command byte
		NBC_OP_ADDR = 3'h1, // four address bytes, low byte first
		NBC_OP_WRITE = 3'h2, // one program data word
		NBC_OP_READ = 3'h3, // one output word
		NBC_OP_WAIT = 3'h4 // wait until the busy line is released
	} nbc_op_t;
	typedef enum logic [2:0] {
		NBC_ST_RECOVER = 3'h0,
		NBC_ST_IDLE = 3'h1,
		NBC_ST_SETUP = 3'h3,
		NBC_ST_STROBE = 3'h2,
		NBC_ST_HOLD = 3'h6,
		NBC_ST_WAIT = 3'h7
	} nbc_state_t;
	typedef struct packed {
		nbc_op_t op;
		logic deselect; // raise chip enable when done
		logic [WDATA_W-1:0] wdata;
	} nbc_req_t;
	typedef struct packed {
		logic [BUS_W-1:0] rdata;
	} nbc_rsp_t;
	typedef struct packed {
		logic ce_n;
		logic command_latch_strobe;
		logic address_latch_strobe;
		logic we_n;
		logic re_n;
		logic wp_n;
	} nbc_pins_t;
	localparam nbc_pins_t PINS_RESET = '{ce_n: 1'b1, command_latch_strobe: 1'b0,
		address_latch_strobe: 1'b0, we_n: 1'b1, re_n: 1'b1, wp_n: 1'b0};
endpackage

// two-flop synchroniser for pins from the flash
module nbc_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta; // first stage, read only by q
	// both stages clear to zero; the busy line is thus seen busy at reset
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule

// ### verif/nbc_flash_model.sv
// behavioural flash device answering the host on its pins
`timescale 1ns/1ns
module nbc_flash_model #(
	parameter logic [15:0] SIG_WORD = 16'hC3A5 // signature word, value arbitrary
) (
	input wire nbc_pkg::nbc_pins_t pins,
	input wire logic [nbc_pkg::BUS_W-1:0] dq_out,
	input wire logic dq_oe_n,
	output logic [nbc_pkg::BUS_W-1:0] dq_in,
	output logic busy_flag_n,
	output int bad_cycles
);
	import nbc_pkg::*;
	logic [15:0] mem [8]; // tiny array, one page
	logic [15:0] page [8]; // program buffer
	logic [7:0] cmd = 8'h00; // last command byte
	logic [2:0] col = 3'h0; // column counter
	int nadr = 0; // address bytes seen
	int busy_ns = 0; // length of the next busy period
	event go_busy;
	initial begin
		bad_cycles = 0;
		dq_in = 16'h0000;
		foreach (mem[i]) mem[i] = 16'hFFFF;
		busy_flag_n = 1'b0;
		#10000 busy_flag_n = 1'b1;
	end
	// busy runs to its end even if chip enable rises meanwhile
	always @(go_busy) begin
		busy_flag_n = 1'b0;
		// release half a cycle off the clock edge, so host sampling never races it
		#(busy_ns + 10) busy_flag_n = 1'b1;
	end
	// bus writes latch on the write rise only
	always @(posedge pins.we_n) begin
		// host must be driving the lanes at every selected write rise
		if (!pins.ce_n && dq_oe_n) begin
			bad_cycles++;
		end
		if (!pins.ce_n && busy_flag_n) begin
			if (pins.command_latch_strobe && pins.address_latch_strobe) begin
				bad_cycles++;
			end else if (pins.command_latch_strobe && pins.re_n) begin
				cmd = dq_out[7:0];
				nadr = 0;
				if (cmd == 8'h80) foreach (page[i]) page[i] = 16'hFFFF;
				// lockout acts on its level at the confirm
				if (cmd == 8'h10 && pins.wp_n) begin
					foreach (mem[i]) mem[i] = mem[i] & page[i];
					busy_ns = 2000;
					-> go_busy;
				end
			end else if (pins.address_latch_strobe && pins.re_n) begin
				if (nadr == 0) col = dq_out[2:0];
				nadr++;
				if (nadr == 4 && cmd == 8'h00) begin
					busy_ns = 1000;
					-> go_busy;
				end
			end else if (pins.re_n) begin
				page[col] = dq_out;
				col++;
			end
		end
	end
	// each read fall presents the next word
	always @(negedge pins.re_n) begin
		// host still driving while the device turns the lanes around is contention
		if (!dq_oe_n) begin
			bad_cycles++;
		end
		if (!pins.ce_n && pins.we_n && !pins.command_latch_strobe && !pins.address_latch_strobe) begin
			#40 dq_in = (cmd == 8'h90) ? SIG_WORD : mem[col];
			col++;
		end
	end
	// released lanes float: show something other than the old word
	always @(posedge pins.re_n or posedge pins.ce_n) begin
		#10 dq_in = ~dq_in;
	end
endmodule

// ### verif/nbc_host_bench.sv
// self-checking bench for the flash bus-cycle host
`timescale 1ns/1ns
module nbc_host_bench;
	import nbc_pkg::*;
	localparam logic [15:0] SIG = 16'h3C96; // arbitrary signature
	logic clk = 1'b0; // 50 MHz
	logic arst_n = 1'b0;
	nbc_req_t req = '0;
	logic req_valid = 1'b0;
	logic prog_allow = 1'b1;
	logic req_ready, rsp_valid, line_ready, dq_oe_n, busy_flag_n;
	nbc_rsp_t rsp;
	nbc_pins_t pins;
	logic [BUS_W-1:0] dq_out, dq_in;
	logic [15:0] rd; // last read word
	int num_errors = 0, check_count = 0, cycles = 0, lat = 0, bad;
	always #10 clk = ~clk;
	nbc_host uut (.clk(clk), .arst_n(arst_n), .req(req), .req_valid(req_valid), .req_ready(req_ready),
		.rsp(rsp), .rsp_valid(rsp_valid), .prog_allow(prog_allow), .line_ready(line_ready), .pins(pins),
		.dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq_in), .busy_flag_n(busy_flag_n));
	nbc_flash_model #(.SIG_WORD(SIG)) dev (.pins(pins), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
		.dq_in(dq_in), .busy_flag_n(busy_flag_n), .bad_cycles(bad));
	// compare and count
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one request; lat counts cycles from take to completion
	task automatic op(input nbc_op_t o, input logic [31:0] w, input logic d);
		@(posedge clk);
		req <= '{op: o, deselect: d, wdata: w};
		req_valid <= 1'b1;
		@(negedge clk);
		while (req_ready !== 1'b1) @(negedge clk);
		@(posedge clk);
		req_valid <= 1'b0;
		lat = 0;
		while (rsp_valid !== 1'b1) begin
			@(negedge clk);
			lat++;
		end
		rd = rsp.rdata;
	endtask
	// program one word; chip enable dropped after the confirm
	task automatic prog(input logic [7:0] c, input logic [15:0] w);
		op(NBC_OP_CMD, 32'h80, 1'b0);
		op(NBC_OP_ADDR, {24'hFFFFFF, c}, 1'b0);
		op(NBC_OP_WRITE, {16'h0, w}, 1'b0);
		op(NBC_OP_CMD, 32'h10, 1'b1);
		op(NBC_OP_WAIT, 32'h0, 1'b0);
	endtask
	// open a page read; enable rises while the read is busy
	task automatic open_read(input logic [7:0] c);
		op(NBC_OP_CMD, 32'h00, 1'b0);
		op(NBC_OP_ADDR, {24'h0, c}, 1'b1);
		op(NBC_OP_WAIT, 32'h0, 1'b0);
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// hang guard, well above the roughly 1100 cycles needed
	always @(posedge clk) begin
		cycles++;
		if (cycles == 8000) begin
			num_errors++;
			end_of_test;
		end
	end
	initial begin
		repeat (8) @(negedge clk);
		check("reset pins", pins, PINS_RESET);
		@(posedge clk);
		arst_n <= 1'b1;
		repeat (400) @(negedge clk);
		// still recovering: write high, lockout low, no request taken
		check("ready in recovery", req_ready, 1'b0);
		check("we in recovery", pins.we_n, 1'b1);
		check("wp in recovery", pins.wp_n, 1'b0);
		check("line in recovery", line_ready, 1'b0);
		op(NBC_OP_CMD, 32'h90, 1'b0);
		check("cmd latency", lat, 6);
		check("line ready", line_ready, 1'b1);
		op(NBC_OP_ADDR, 32'h0, 1'b0);
		check("addr latency", lat, 21);
		op(NBC_OP_READ, 32'h0, 1'b0);
		check("read latency", lat, 10);
		check("signature", rd, SIG);
		prog(8'h02, 16'h1234);
		check("program busy", lat >= 100, 1'b1);
		prog(8'h03, 16'hABCD);
		open_read(8'h02);
		op(NBC_OP_READ, 32'h0, 1'b0);
		check("word 2", rd, 16'h1234);
		op(NBC_OP_READ, 32'h0, 1'b1);
		check("word 3", rd, 16'hABCD);
		check("deselected", pins.ce_n, 1'b1);
		@(posedge clk);
		prog_allow <= 1'b0;
		prog(8'h02, 16'h0000);
		check("locked no busy", lat < 100, 1'b1);
		check("wp follows", pins.wp_n, 1'b0);
		open_read(8'h02);
		op(NBC_OP_READ, 32'h0, 1'b1);
		check("locked word", rd, 16'h1234);
		check("strobe clash", bad, 0);
		end_of_test;
	end
endmodule
